//--- rtl/tlm_pkg.sv
// Purpose: Constants and types for the TLB maintenance block
// Assumes: 32-bit staging registers, APB register access, one clock
// Notes: Field positions follow the staging register layout below
// Operation
// - A read loads entry high, both entry lows and the page size mask from the entry at index.
// - A read may return the page pair number with bits under the entry's mask zeroed.
// - A read may return each frame number with bits under the entry's mask zeroed.
// - A read places the entry's single global bit into both entry low registers.
// - With the system coprocessor disabled every TLB op raises coprocessor-unusable instead.
// - Opcode 010000, operation bit set, function 000010 writes the entry at index.
// - Opcode 010000, operation bit set, function 000110 writes the entry at the random pointer.
// - Writes take the staging registers; mask, region and space identifier go in unchanged.
// - A write that would duplicate a matching entry signals a machine check.
// - A multiple match is reported only on a write, never on a read.
// - A write may store the page pair number with bits under the page mask zeroed.
// - A write may store both frame numbers with bits under the page mask zeroed.
// - A write stores the global bit as the AND of both entry low global bits.
// - A write copies cacheability, dirty and valid of each entry low into that page.
package tlm_pkg;
    // Register byte offsets
    localparam logic [7:0] TLM_OFF_INDEX = 8'h00;
    localparam logic [7:0] TLM_OFF_RANDOM = 8'h04;
    localparam logic [7:0] TLM_OFF_HIGH = 8'h08;
    localparam logic [7:0] TLM_OFF_LOW_EVEN = 8'h0c;
    localparam logic [7:0] TLM_OFF_LOW_ODD = 8'h10;
    localparam logic [7:0] TLM_OFF_MASK = 8'h14;
    localparam logic [7:0] TLM_OFF_CTRL = 8'h18;
    localparam logic [7:0] TLM_OFF_STATUS = 8'h1c;
    localparam logic [7:0] TLM_OFF_INT_MASK = 8'h20;
    // Field positions
    localparam int TLM_VIRTUAL_PAGE_PAIR_NUMBER_LSB = 13;
    localparam int TLM_VIRTUAL_PAGE_PAIR_NUMBER_W = 19;
    localparam int TLM_REGION_LSB = 11;
    localparam int TLM_REGION_W = 2;
    localparam int TLM_ADDRESS_SPACE_IDENTIFIER_W = 8;
    localparam int TLM_PFN_LSB = 6;
    localparam int TLM_PFN_W = 20;
    localparam int TLM_C_LSB = 3;
    localparam int TLM_C_W = 3;
    localparam int TLM_D_BIT = 2;
    localparam int TLM_V_BIT = 1;
    localparam int TLM_G_BIT = 0;
    localparam int TLM_MASK_LSB = 13;
    localparam int TLM_MASK_W = 16;
    localparam int TLM_CTRL_EN_BIT = 0;
    localparam int TLM_EV_W = 3;
    localparam int TLM_EV_DONE = 0;
    localparam int TLM_EV_UNUSABLE = 1;
    localparam int TLM_EV_MCHECK = 2;
    // Reset values
    localparam logic [31:0] TLM_RST_WORD = 32'h0000_0000;
    localparam logic [31:0] TLM_RST_CTRL = 32'h0000_0001;
    // Instruction decode
    localparam logic [5:0] TLM_OP_SYSCOP = 6'h10;
    localparam int TLM_OPC_LSB = 26;
    localparam int TLM_COP_BIT = 25;
    localparam logic [5:0] TLM_FN_READ = 6'h01;
    localparam logic [5:0] TLM_FN_WR_INDEXED = 6'h02;
    localparam logic [5:0] TLM_FN_WR_RANDOM = 6'h06;
    // Default sizes
    localparam int TLM_ENTRIES_DEF = 16;

    typedef struct packed {
        logic [TLM_MASK_W-1:0] mask;
        logic [TLM_REGION_W-1:0] region;
        logic [TLM_VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] virtual_page_pair_number;
        logic [TLM_ADDRESS_SPACE_IDENTIFIER_W-1:0] address_space_identifier;
        logic g;
        logic [TLM_PFN_W-1:0] even_page_frame;
        logic [TLM_C_W-1:0] c0;
        logic d0;
        logic v0;
        logic [TLM_PFN_W-1:0] odd_page_frame;
        logic [TLM_C_W-1:0] c1;
        logic d1;
        logic v1;
    } tlm_entry_type;
endpackage

//--- rtl/tlm_tlb_if.sv
// Purpose: Carrier between the maintenance control and the entry array
// Assumes: One clock domain
// Notes: Write candidate is also the multiple-match probe value
`timescale 1ns/100ps
`default_nettype none
interface tlm_tlb_if #(parameter int IW = 4);
    import tlm_pkg::*;
    logic wr_en;
    logic [IW-1:0] wr_idx;
    tlm_entry_type wr_entry;
    logic [IW-1:0] rd_idx;
    tlm_entry_type rd_entry;
    logic multi_hit;
    modport ctrl (output wr_en, output wr_idx, output wr_entry, output rd_idx,
        input rd_entry, input multi_hit);
    modport array (input wr_en, input wr_idx, input wr_entry, input rd_idx,
        output rd_entry, output multi_hit);
endinterface
`default_nettype wire

//--- rtl/tlm_tlb_array.sv
// Purpose: TLB entry storage with duplicate detection against a candidate
// Assumes: Candidate and target index are stable within the write cycle
// Notes: Only entries written since reset take part in matching
`timescale 1ns/100ps
`default_nettype none
module tlm_tlb_array import tlm_pkg::*; #(
    parameter int ENTRIES = TLM_ENTRIES_DEF,
    parameter int IW = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control side
    tlm_tlb_if.array tif
);
    tlm_entry_type mem [ENTRIES];
    logic [ENTRIES-1:0] used;
    logic [ENTRIES-1:0] hit;
    tlm_entry_type c;

    assign c = tif.wr_entry;

    genvar i;
    generate
        for (i = 0; i < ENTRIES; i++) begin : g_entry
            logic [TLM_VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] cmp_mask;
            assign cmp_mask = ~{3'b000, (mem[i].mask | c.mask)};
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem[i] <= '0;
                    used[i] <= 1'b0;
                end else if (tif.wr_en && tif.wr_idx == IW'(i)) begin
                    mem[i] <= c;
                    used[i] <= 1'b1;
                end
            end
            // Overwriting the target itself is never a duplicate
            assign hit[i] = used[i] && (tif.wr_idx != IW'(i))
                && ((mem[i].virtual_page_pair_number & cmp_mask) == (c.virtual_page_pair_number & cmp_mask))
                && (mem[i].region == c.region)
                && ((mem[i].g && c.g) || (mem[i].address_space_identifier == c.address_space_identifier));
        end
    endgenerate

    assign tif.multi_hit = |hit;
    assign tif.rd_entry = (32'(tif.rd_idx) < ENTRIES) ? mem[tif.rd_idx] : '0;
endmodule
`default_nettype wire

//--- rtl/tlm_tlb_maint.sv
// Purpose: TLB read, indexed write and random write with APB staging registers
// Assumes: Instruction word presented with instr_valid for one cycle
// Notes: Out-of-range index makes read and indexed write do nothing
`timescale 1ns/100ps
`default_nettype none
module tlm_tlb_maint import tlm_pkg::*; #(
    parameter int ENTRIES = TLM_ENTRIES_DEF,
    parameter bit ZERO_MASKED = 1'b1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pipeline issue
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    // Results and interrupt
    output logic op_done,
    output logic cpu_unusable_exc,
    output logic machine_check_exc,
    output logic irq
);
    localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
    localparam logic [IW-1:0] LAST_IDX = IW'(ENTRIES - 1);

    // Refused at elaboration: the pointer and duplicate logic only serve this range
    if (ENTRIES < 2 || ENTRIES > 64) begin : g_bad_entries
        $error("ENTRIES must be between 2 and 64");
    end


    tlm_tlb_if #(.IW(IW)) tif ();

    tlm_tlb_array #(.ENTRIES(ENTRIES), .IW(IW)) u_array (
        .clk(pclk),
        .rst_n(presetn),
        .tif(tif.array)
    );

    logic [31:0] index_reg;
    logic [IW-1:0] random_reg;
    logic [31:0] entry_high_reg;
    logic [31:0] entry_low_even_reg;
    logic [31:0] entry_low_odd_reg;
    logic [31:0] page_size_mask_reg;
    logic [31:0] ctrl_reg;
    logic [TLM_EV_W-1:0] status_reg;
    logic [TLM_EV_W-1:0] int_mask_reg;
    logic [TLM_EV_W-1:0] status_next;
    logic [TLM_EV_W-1:0] ev_set;
    logic [TLM_EV_W-1:0] ev_clr;

    // Instruction decode
    logic is_cop_op;
    logic op_read;
    logic op_wr_indexed;
    logic op_wr_random;
    logic any_op;
    logic usable;
    logic idx_ok;
    logic do_read;
    logic wr_req;
    logic mc_ev;
    logic unusable_ev;
    logic [5:0] funct;

    assign funct = instr_word[5:0];
    assign is_cop_op = (instr_word[31:TLM_OPC_LSB] == TLM_OP_SYSCOP)
        && instr_word[TLM_COP_BIT];
    assign op_read = instr_valid && is_cop_op && (funct == TLM_FN_READ);
    assign op_wr_indexed = instr_valid && is_cop_op
        && (funct == TLM_FN_WR_INDEXED);
    assign op_wr_random = instr_valid && is_cop_op
        && (funct == TLM_FN_WR_RANDOM);
    assign any_op = op_read || op_wr_indexed || op_wr_random;
    assign usable = ctrl_reg[TLM_CTRL_EN_BIT];
    // Undefined range: the op is dropped so no entry outside the array is touched
    assign idx_ok = index_reg < 32'(ENTRIES);
    assign unusable_ev = any_op && !usable;
    assign do_read = op_read && usable && idx_ok;
    assign wr_req = usable && ((op_wr_indexed && idx_ok) || op_wr_random);
    // Duplicate check only runs for writes, so reads never report one
    assign mc_ev = wr_req && tif.multi_hit;

    // Write candidate built from the staging registers
    logic [TLM_MASK_W-1:0] pm;
    logic [TLM_VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] vpn_keep;
    logic [TLM_PFN_W-1:0] pfn_keep;
    tlm_entry_type cand;

    assign pm = page_size_mask_reg[TLM_MASK_LSB +: TLM_MASK_W];
    assign vpn_keep = ZERO_MASKED ? ~{3'b000, pm} : '1;
    assign pfn_keep = ZERO_MASKED ? ~{4'h0, pm} : '1;

    always_comb begin
        cand = '0;
        cand.mask = pm;
        cand.region = entry_high_reg[TLM_REGION_LSB +: TLM_REGION_W];
        cand.address_space_identifier = entry_high_reg[TLM_ADDRESS_SPACE_IDENTIFIER_W-1:0];
        cand.virtual_page_pair_number = entry_high_reg[TLM_VIRTUAL_PAGE_PAIR_NUMBER_LSB +: TLM_VIRTUAL_PAGE_PAIR_NUMBER_W] & vpn_keep;
        cand.g = entry_low_even_reg[TLM_G_BIT] & entry_low_odd_reg[TLM_G_BIT];
        cand.even_page_frame = entry_low_even_reg[TLM_PFN_LSB +: TLM_PFN_W] & pfn_keep;
        cand.odd_page_frame = entry_low_odd_reg[TLM_PFN_LSB +: TLM_PFN_W] & pfn_keep;
        cand.c0 = entry_low_even_reg[TLM_C_LSB +: TLM_C_W];
        cand.d0 = entry_low_even_reg[TLM_D_BIT];
        cand.v0 = entry_low_even_reg[TLM_V_BIT];
        cand.c1 = entry_low_odd_reg[TLM_C_LSB +: TLM_C_W];
        cand.d1 = entry_low_odd_reg[TLM_D_BIT];
        cand.v1 = entry_low_odd_reg[TLM_V_BIT];
    end

    assign tif.wr_entry = cand;
    assign tif.wr_idx = op_wr_random ? random_reg : index_reg[IW-1:0];
    assign tif.wr_en = wr_req && !tif.multi_hit;
    assign tif.rd_idx = index_reg[IW-1:0];

    // Read unpacking
    tlm_entry_type re;
    logic [TLM_VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] rd_vpn_keep;
    logic [TLM_PFN_W-1:0] rd_pfn_keep;
    logic [31:0] high_next;
    logic [31:0] low_even_next;
    logic [31:0] low_odd_next;
    logic [31:0] mask_next;

    assign re = tif.rd_entry;
    assign rd_vpn_keep = ZERO_MASKED ? ~{3'b000, re.mask} : '1;
    assign rd_pfn_keep = ZERO_MASKED ? ~{4'h0, re.mask} : '1;

    always_comb begin
        high_next = '0;
        high_next[TLM_VIRTUAL_PAGE_PAIR_NUMBER_LSB +: TLM_VIRTUAL_PAGE_PAIR_NUMBER_W] = re.virtual_page_pair_number & rd_vpn_keep;
        high_next[TLM_REGION_LSB +: TLM_REGION_W] = re.region;
        high_next[TLM_ADDRESS_SPACE_IDENTIFIER_W-1:0] = re.address_space_identifier;
        low_even_next = '0;
        low_even_next[TLM_PFN_LSB +: TLM_PFN_W] = re.even_page_frame & rd_pfn_keep;
        low_even_next[TLM_C_LSB +: TLM_C_W] = re.c0;
        low_even_next[TLM_D_BIT] = re.d0;
        low_even_next[TLM_V_BIT] = re.v0;
        low_even_next[TLM_G_BIT] = re.g;
        low_odd_next = '0;
        low_odd_next[TLM_PFN_LSB +: TLM_PFN_W] = re.odd_page_frame & rd_pfn_keep;
        low_odd_next[TLM_C_LSB +: TLM_C_W] = re.c1;
        low_odd_next[TLM_D_BIT] = re.d1;
        low_odd_next[TLM_V_BIT] = re.v1;
        low_odd_next[TLM_G_BIT] = re.g;
        mask_next = '0;
        mask_next[TLM_MASK_LSB +: TLM_MASK_W] = re.mask;
    end

    // APB decode
    logic apb_wr;
    logic apb_setup_rd;
    logic addr_ok;

    assign pready = 1'b1;
    assign apb_wr = psel && penable && pwrite;
    assign apb_setup_rd = psel && !penable && !pwrite;
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= TLM_OFF_INT_MASK);
    assign pslverr = psel && penable && !addr_ok;

    // Staging registers: a TLB read in the same cycle wins over an APB write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry_high_reg <= TLM_RST_WORD;
            entry_low_even_reg <= TLM_RST_WORD;
            entry_low_odd_reg <= TLM_RST_WORD;
            page_size_mask_reg <= TLM_RST_WORD;
        end else if (do_read) begin
            entry_high_reg <= high_next;
            entry_low_even_reg <= low_even_next;
            entry_low_odd_reg <= low_odd_next;
            page_size_mask_reg <= mask_next;
        end else if (apb_wr) begin
            if (paddr == TLM_OFF_HIGH) begin
                entry_high_reg <= pwdata;
            end
            if (paddr == TLM_OFF_LOW_EVEN) begin
                entry_low_even_reg <= pwdata;
            end
            if (paddr == TLM_OFF_LOW_ODD) begin
                entry_low_odd_reg <= pwdata;
            end
            if (paddr == TLM_OFF_MASK) begin
                page_size_mask_reg <= pwdata;
            end
        end
    end

    // Software controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_reg <= TLM_RST_WORD;
            ctrl_reg <= TLM_RST_CTRL;
            int_mask_reg <= '0;
        end else if (apb_wr) begin
            if (paddr == TLM_OFF_INDEX) begin
                index_reg <= pwdata;
            end
            if (paddr == TLM_OFF_CTRL) begin
                ctrl_reg <= {31'h0000_0000, pwdata[TLM_CTRL_EN_BIT]};
            end
            if (paddr == TLM_OFF_INT_MASK) begin
                int_mask_reg <= pwdata[TLM_EV_W-1:0];
            end
        end
    end

    // Replacement pointer counts down and wraps inside the array
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            random_reg <= LAST_IDX;
        end else if (random_reg == '0) begin
            random_reg <= LAST_IDX;
        end else begin
            random_reg <= random_reg - 1'b1;
        end
    end

    // Sticky events, write one to clear; a new event beats its clear
    always_comb begin
        ev_set = '0;
        ev_set[TLM_EV_DONE] = do_read || tif.wr_en;
        ev_set[TLM_EV_UNUSABLE] = unusable_ev;
        ev_set[TLM_EV_MCHECK] = mc_ev;
        ev_clr = (apb_wr && paddr == TLM_OFF_STATUS) ? pwdata[TLM_EV_W-1:0] : '0;
        status_next = (status_reg & ~ev_clr) | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= '0;
            irq <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq <= |(status_next & int_mask_reg);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_done <= 1'b0;
            cpu_unusable_exc <= 1'b0;
            machine_check_exc <= 1'b0;
        end else begin
            op_done <= ev_set[TLM_EV_DONE];
            cpu_unusable_exc <= unusable_ev;
            machine_check_exc <= mc_ev;
        end
    end

    // Read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (apb_setup_rd) begin
            unique case (paddr)
                TLM_OFF_INDEX: prdata <= index_reg;
                TLM_OFF_RANDOM: prdata <= 32'(random_reg);
                TLM_OFF_HIGH: prdata <= entry_high_reg;
                TLM_OFF_LOW_EVEN: prdata <= entry_low_even_reg;
                TLM_OFF_LOW_ODD: prdata <= entry_low_odd_reg;
                TLM_OFF_MASK: prdata <= page_size_mask_reg;
                TLM_OFF_CTRL: prdata <= ctrl_reg;
                TLM_OFF_STATUS: prdata <= 32'(status_reg);
                TLM_OFF_INT_MASK: prdata <= 32'(int_mask_reg);
                default: prdata <= '0;
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_read_mask;
        do_read |=> page_size_mask_reg[TLM_MASK_LSB +: TLM_MASK_W] == $past(re.mask);
    endproperty
    a_read_mask: assert property (p_read_mask) else $error("read mask wrong");

    property p_read_vpn_zero;
        (do_read && ZERO_MASKED) |=> ((entry_high_reg[TLM_VIRTUAL_PAGE_PAIR_NUMBER_LSB +: TLM_MASK_W]
            & page_size_mask_reg[TLM_MASK_LSB +: TLM_MASK_W]) == '0);
    endproperty
    a_read_vpn_zero: assert property (p_read_vpn_zero) else $error("vpn bits kept");

    property p_read_pfn_zero;
        (do_read && ZERO_MASKED) |=> ((entry_low_odd_reg[TLM_PFN_LSB +: TLM_MASK_W]
            & page_size_mask_reg[TLM_MASK_LSB +: TLM_MASK_W]) == '0);
    endproperty
    a_read_pfn_zero: assert property (p_read_pfn_zero) else $error("pfn bits kept");

    property p_read_global;
        do_read |=> (entry_low_even_reg[TLM_G_BIT] == entry_low_odd_reg[TLM_G_BIT])
            && (entry_low_odd_reg[TLM_G_BIT] == $past(re.g));
    endproperty
    a_read_global: assert property (p_read_global) else $error("global bit split");

    property p_unusable;
        (any_op && !usable) |-> !tif.wr_en ##1 cpu_unusable_exc && !op_done;
    endproperty
    a_unusable: assert property (p_unusable) else $error("unusable op acted");

    property p_wr_indexed;
        (op_wr_indexed && usable && idx_ok && !tif.multi_hit)
            |-> tif.wr_en && (tif.wr_idx == index_reg[IW-1:0]);
    endproperty
    a_wr_indexed: assert property (p_wr_indexed) else $error("indexed write missed");

    property p_wr_random;
        (op_wr_random && usable && !tif.multi_hit) |-> tif.wr_en && (tif.wr_idx == random_reg);
    endproperty
    a_wr_random: assert property (p_wr_random) else $error("random write missed");

    property p_wr_fields;
        tif.wr_en |-> (cand.address_space_identifier == entry_high_reg[TLM_ADDRESS_SPACE_IDENTIFIER_W-1:0])
            && (cand.mask == page_size_mask_reg[TLM_MASK_LSB +: TLM_MASK_W])
            && (cand.v1 == entry_low_odd_reg[TLM_V_BIT])
            && (cand.d0 == entry_low_even_reg[TLM_D_BIT]);
    endproperty
    a_wr_fields: assert property (p_wr_fields) else $error("write field changed");

    property p_mcheck;
        (wr_req && tif.multi_hit) |-> !tif.wr_en
            ##1 machine_check_exc && status_reg[TLM_EV_MCHECK];
    endproperty
    a_mcheck: assert property (p_mcheck) else $error("duplicate not flagged");

    property p_mcheck_only_write;
        machine_check_exc |-> $past(op_wr_indexed || op_wr_random);
    endproperty
    a_mcheck_only_write: assert property (p_mcheck_only_write)
        else $error("mcheck off write");

    property p_wr_vpn_zero;
        (tif.wr_en && ZERO_MASKED) |-> ((cand.virtual_page_pair_number[TLM_MASK_W-1:0] & cand.mask) == '0)
            && ((cand.even_page_frame[TLM_MASK_W-1:0] & cand.mask) == '0);
    endproperty
    a_wr_vpn_zero: assert property (p_wr_vpn_zero) else $error("masked bits stored");

    property p_wr_global;
        tif.wr_en |-> tif.wr_entry.g
            == (entry_low_even_reg[TLM_G_BIT] && entry_low_odd_reg[TLM_G_BIT]);
    endproperty
    a_wr_global: assert property (p_wr_global) else $error("global not anded");

    property p_random_range;
        32'(random_reg) < ENTRIES ##1 32'(random_reg) < ENTRIES;
    endproperty
    a_random_range: assert property (p_random_range)
        else $error("random out of range");

    c_read: cover property (do_read ##1 op_done);
    c_wr_random: cover property (op_wr_random && tif.wr_en);
    c_dup: cover property (wr_req && tif.multi_hit);
    c_unusable: cover property (unusable_ev ##1 irq);
endmodule
`default_nettype wire

//--- tb/tlm_pipe_model.sv
// Purpose: Pipeline model issuing TLB maintenance instructions
// Assumes: One instruction word per go pulse from the bench
// Notes: Idle words carry a foreign opcode so the block never decodes them
`timescale 1ns/100ps
`default_nettype none
module tlm_pipe_model import tlm_pkg::*; (
    // Clock
    input wire logic pclk,
    // Command from bench
    input wire logic go,
    input wire logic [5:0] fn,
    // Issue
    output logic instr_valid,
    output logic [31:0] instr_word
);
    always @(posedge pclk) begin
        instr_valid <= go;
        if (go) begin
            instr_word <= {TLM_OP_SYSCOP, 1'b1, 19'h0, fn};
        end else begin
            instr_word <= {6'h00, 26'($urandom)};
        end
    end
endmodule
`default_nettype wire

//--- tb/tlm_tlb_maint_tb.sv
// Purpose: Self-checking bench for the TLB maintenance block
// Assumes: Masked bits zeroed, 16 entries
// Notes: Bench arrays hold the expected read image of every entry
`timescale 1ns/100ps
`default_nettype none
module tlm_tlb_maint_tb;
    import tlm_pkg::*;
    localparam int N = 16;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [5:0] fn = 6'h00;
    logic [31:0] pwdata = 32'h0, prdata, instr_word, q, h, l0, l1, m, sh, s0, s1, sm, sh0;
    logic pready, pslverr, instr_valid, op_done, unus, mchk, irq, err;
    logic [2:0] pulses;
    logic [31:0] mh [N+1] = '{default: 32'h0};
    logic [31:0] ml0 [N+1] = '{default: 32'h0};
    logic [31:0] ml1 [N+1] = '{default: 32'h0};
    logic [31:0] mm [N+1] = '{default: 32'h0};
    logic [5:0] fns [3] = '{TLM_FN_READ, TLM_FN_WR_INDEXED, TLM_FN_WR_RANDOM};
    int fail_count = 0, total_checks = 0, hits;
    always #50 pclk = ~pclk;
    tlm_tlb_maint #(.ENTRIES(N), .ZERO_MASKED(1'b1)) tlm_tlb_maint_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_valid(instr_valid), .instr_word(instr_word), .op_done(op_done),
        .cpu_unusable_exc(unus), .machine_check_exc(mchk), .irq(irq));
    tlm_pipe_model tlm_pipe_model_inst (.pclk(pclk), .go(go), .fn(fn),
        .instr_valid(instr_valid), .instr_word(instr_word));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", s, e, g);
            fail_count++;
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // The pulse stands only in the cycle after the taking edge
    task automatic op(input logic [5:0] f);
        @(posedge pclk);
        go <= 1'b1;
        fn <= f;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        #1 pulses = {mchk, unus, op_done};
    endtask
    task automatic stage();
        apb(1'b1, TLM_OFF_HIGH, sh);
        apb(1'b1, TLM_OFF_LOW_EVEN, s0);
        apb(1'b1, TLM_OFF_LOW_ODD, s1);
        apb(1'b1, TLM_OFF_MASK, sm);
    endtask
    task automatic mput(input int j);
        logic [31:0] k;
        k = sm & 32'h1fffe000;
        mm[j] = k;
        mh[j] = sh & ~k & 32'hfffff8ff;
        ml0[j] = (s0 & ~(k >> 7) & 32'h03fffffe) | 32'(s0[0] & s1[0]);
        ml1[j] = (s1 & ~(k >> 7) & 32'h03fffffe) | 32'(s0[0] & s1[0]);
    endtask
    task automatic rd_entry(input int j);
        apb(1'b1, TLM_OFF_INDEX, 32'(j));
        op(TLM_FN_READ);
        chk("read pulses", 32'h1, 32'(pulses));
        apb(1'b0, TLM_OFF_HIGH, 32'h0);
        h = q;
        apb(1'b0, TLM_OFF_LOW_EVEN, 32'h0);
        l0 = q;
        apb(1'b0, TLM_OFF_LOW_ODD, 32'h0);
        l1 = q;
        apb(1'b0, TLM_OFF_MASK, 32'h0);
        m = q;
    endtask
    task automatic cmp(input int j);
        chk("entry high", mh[j], h);
        chk("entry low even", ml0[j], l0);
        chk("entry low odd", ml1[j], l1);
        chk("page mask", mm[j], m);
    endtask
    initial begin
        #2000000;
        fail_count++;
        stop_test();
    end
    initial begin
        void'($urandom(19));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, TLM_OFF_CTRL, 32'h0);
        chk("ctrl reset", TLM_RST_CTRL, q);
        apb(1'b0, TLM_OFF_RANDOM, 32'h0);
        chk("random in range", 32'h1, 32'(q < N));
        // Top bits keep the eight entries apart so none duplicates another
        for (int i = 0; i < 8; i++) begin
            sh = {3'(i), 18'($urandom), 3'h0, 8'(i)};
            s0 = $urandom;
            s1 = $urandom;
            sm = $urandom;
            if (i == 0) sh0 = sh;
            stage();
            apb(1'b1, TLM_OFF_INDEX, 32'(i));
            op(TLM_FN_WR_INDEXED);
            chk("write pulses", 32'h1, 32'(pulses));
            mput(i);
        end
        for (int i = 0; i < 8; i++) begin
            rd_entry(i);
            cmp(i);
        end
        sh = sh0;
        stage();
        apb(1'b1, TLM_OFF_INDEX, 32'h8);
        op(TLM_FN_WR_INDEXED);
        chk("duplicate pulses", 32'h4, 32'(pulses));
        rd_entry(8);
        cmp(8);
        sh = {24'($urandom), 8'hff} & 32'hfffff8ff;
        s0 = $urandom & 32'hfffffffe;
        s1 = $urandom & 32'hfffffffe;
        sm = $urandom;
        stage();
        op(TLM_FN_WR_RANDOM);
        chk("random pulses", 32'h1, 32'(pulses));
        mput(N);
        hits = 0;
        for (int j = 0; j < N; j++) begin
            rd_entry(j);
            if (h === mh[N] && l0 === ml0[N] && l1 === ml1[N] && m === mm[N]) begin
                hits++;
                mh[j] = mh[N];
                ml0[j] = ml0[N];
                ml1[j] = ml1[N];
                mm[j] = mm[N];
            end
            cmp(j);
        end
        chk("random targets", 32'h1, 32'(hits));
        apb(1'b1, TLM_OFF_CTRL, 32'h0);
        for (int k = 0; k < 3; k++) begin
            op(fns[k]);
            chk("disabled pulses", 32'h2, 32'(pulses));
        end
        apb(1'b0, TLM_OFF_HIGH, 32'h0);
        chk("high kept", h, q);
        apb(1'b1, TLM_OFF_CTRL, 32'h1);
        apb(1'b0, TLM_OFF_STATUS, 32'h0);
        chk("status", 32'h7, q);
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, TLM_OFF_INT_MASK, 32'h2);
        apb(1'b0, TLM_OFF_STATUS, 32'h0);
        chk("irq raised", 32'h1, 32'(irq));
        apb(1'b1, TLM_OFF_STATUS, 32'h7);
        apb(1'b0, TLM_OFF_STATUS, 32'h0);
        chk("status cleared", 32'h0, q);
        chk("irq cleared", 32'h0, 32'(irq));
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, q);
        stop_test();
    end
endmodule
`default_nettype wire
